// [design/tpgw_pkg.sv]
package tpgw_pkg;

  // ****************************************
  // Geometry and reset values
  // ****************************************
  localparam int NUM_PORTS = 3;
  localparam int PORT_W = 8;
  localparam int NUM_PINS = NUM_PORTS * PORT_W;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
  // Weak pull-up strength, for the pad model only
  localparam int PULLUP_KOHM = 100;

  // ****************************************
  // Register offsets on the special function bus
  // ****************************************
  localparam logic [7:0] ADDR_PORT0_DATA = 8'h80;
  localparam logic [7:0] ADDR_PORT1_DATA = 8'h90;
  localparam logic [7:0] ADDR_PORT3_DATA = 8'hB0;
  localparam logic [7:0] ADDR_PORT3_PULLUP = 8'hAA;
  localparam logic [7:0] ADDR_PORT3_DRIVE = 8'hAB;
  localparam logic [7:0] ADDR_PORT3_WAKE = 8'hAC;
  localparam logic [7:0] ADDR_PORT0_PULLUP = 8'hB2;
  localparam logic [7:0] ADDR_PORT0_DRIVE = 8'hB3;
  localparam logic [7:0] ADDR_PORT0_WAKE = 8'hB4;
  localparam logic [7:0] ADDR_PORT1_PULLUP = 8'hB5;
  localparam logic [7:0] ADDR_PORT1_DRIVE = 8'hB6;
  localparam logic [7:0] ADDR_PORT1_WAKE = 8'hB7;
  // Pin function select, one bit per pin, 1 hands the pin to a peripheral
  localparam logic [7:0] ADDR_PORT0_FUNC = 8'hC1;
  localparam logic [7:0] ADDR_PORT1_FUNC = 8'hC2;
  localparam logic [7:0] ADDR_PORT3_FUNC = 8'hC3;

  // Port slot numbers inside the block
  localparam logic [1:0] SLOT_PORT0 = 2'h0;
  localparam logic [1:0] SLOT_PORT1 = 2'h1;
  localparam logic [1:0] SLOT_PORT3 = 2'h2;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    KIND_DATA,
    KIND_PULL,
    KIND_DRIVE,
    KIND_WAKE,
    KIND_FUNC
  } tpgw_kind_type;

  typedef struct packed {
    logic valid;
    tpgw_kind_type kind;
    logic [1:0] slot;
  } tpgw_hit_type;

  // Special function bus request from the core
  typedef struct packed {
    logic rd;
    logic rmw;
    logic wr;
    logic bitWr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [2:0] bitSel;
    logic bitVal;
  } tpgw_sfr_req_type;

  // Pad controls for all pins
  typedef struct packed {
    logic [NUM_PINS-1:0] out;
    logic [NUM_PINS-1:0] oenN;
    logic [NUM_PINS-1:0] pullUpEnable;
  } tpgw_pad_type;

endpackage : tpgw_pkg

// [design/tpgw_top.sv]
// What this block does
// - Twenty-four pins in three independent eight-bit ports, each pin controlled alone.
// - A per-pin select register hands each pin to a peripheral or GPIO.
// - Each port data register has its own address, byte and bit access, resets zero.
// - An ordinary data register read returns the pin levels, not the latch.
// - Read-modify-write reads return the output latch instead of the pins.
// - Drive enable set drives the latch value; pad input value follows it.
// - Drive off, pull-up on: weak pull-up input, pad level is returned.
// - Drive and pull-up off: high-impedance input, external level is returned.
// - Any GPIO pin can wake the part, under its wake control bit.
// - Wake term is 1 when its bit is set or the pin is a peripheral's, else pad; all ANDed.
// - Per-port pull-up, drive and wake registers at fixed addresses, reset zero.
// - Wake interrupt flag mirrors the wake line every clock; software cannot set it.
module tpgw_top #(
  parameter int PORT_WIDTH = 8
) (
  input wire logic core_clk,                              // System clock
  input wire logic rstn,                                  // Synchronous reset
  input wire tpgw_pkg::tpgw_sfr_req_type sfrReq,          // Register request
  output logic [7:0] sfrRdata,                            // Read data, one cycle later
  input wire logic [tpgw_pkg::NUM_PINS-1:0] padIn,        // Pin levels from pads
  output tpgw_pkg::tpgw_pad_type padCtrl,                 // Pad drive controls
  input wire logic [tpgw_pkg::NUM_PINS-1:0] periphOut,    // Peripheral output values
  input wire logic [tpgw_pkg::NUM_PINS-1:0] periphOe,     // Peripheral drive enables
  output logic [tpgw_pkg::NUM_PINS-1:0] periphIn,         // Pad input values to peripherals
  output logic pinWakeIrqLine,                            // AND of all wake terms
  output logic pinWakeIrqFlag                             // Flag copy of the wake line
);

  // ****************************************
  // Elaboration check
  // ****************************************
  if (PORT_WIDTH != tpgw_pkg::PORT_W)
  begin : gWidthCheck
    $error("tpgw_top supports eight-bit ports only");
  end

  // Package geometry must agree with the port count
  if (tpgw_pkg::NUM_PINS != tpgw_pkg::NUM_PORTS * tpgw_pkg::PORT_W)
  begin : gPinCheck
    $error("tpgw_top pin count must match its ports");
  end

  // Port slots are two bits wide
  if (tpgw_pkg::NUM_PORTS > 4)
  begin : gSlotCheck
    $error("tpgw_top supports at most four port slots");
  end

  // ****************************************
  // State
  // ****************************************
  // All state in one struct: one comb fills a copy, one flop bank holds it
  typedef struct packed {
    logic [tpgw_pkg::NUM_PORTS-1:0][7:0] data;
    logic [tpgw_pkg::NUM_PORTS-1:0][7:0] pullUpEnable;
    logic [tpgw_pkg::NUM_PORTS-1:0][7:0] driveEnable;
    logic [tpgw_pkg::NUM_PORTS-1:0][7:0] wakeControlReg;
    logic [tpgw_pkg::NUM_PORTS-1:0][7:0] funcSel;
    logic [tpgw_pkg::NUM_PINS-1:0] padSync1;
    logic [tpgw_pkg::NUM_PINS-1:0] padSync2;
    logic [7:0] rdata;
    tpgw_pkg::tpgw_pad_type pad;
    logic [tpgw_pkg::NUM_PINS-1:0] periphIn;
    logic wakeLine;
    logic wakeFlag;
  } tpgw_state_type;

  tpgw_state_type state_q;
  tpgw_state_type state_d;

  // ****************************************
  // Address decode
  // ****************************************
  // Unmapped addresses read zero and ignore writes
  function automatic tpgw_pkg::tpgw_hit_type decodeAddr(input logic [7:0] addr);
    tpgw_pkg::tpgw_hit_type hit;
    // Valid until the default branch finds no register
    hit.valid = 1'b1;
    hit.kind = tpgw_pkg::KIND_DATA;
    hit.slot = tpgw_pkg::SLOT_PORT0;
    unique case (addr)
      tpgw_pkg::ADDR_PORT0_DATA:
      begin
        hit.kind = tpgw_pkg::KIND_DATA;
        hit.slot = tpgw_pkg::SLOT_PORT0;
      end
      tpgw_pkg::ADDR_PORT1_DATA:
      begin
        hit.kind = tpgw_pkg::KIND_DATA;
        hit.slot = tpgw_pkg::SLOT_PORT1;
      end
      tpgw_pkg::ADDR_PORT3_DATA:
      begin
        hit.kind = tpgw_pkg::KIND_DATA;
        hit.slot = tpgw_pkg::SLOT_PORT3;
      end
      tpgw_pkg::ADDR_PORT0_PULLUP:
      begin
        hit.kind = tpgw_pkg::KIND_PULL;
        hit.slot = tpgw_pkg::SLOT_PORT0;
      end
      tpgw_pkg::ADDR_PORT1_PULLUP:
      begin
        hit.kind = tpgw_pkg::KIND_PULL;
        hit.slot = tpgw_pkg::SLOT_PORT1;
      end
      tpgw_pkg::ADDR_PORT3_PULLUP:
      begin
        hit.kind = tpgw_pkg::KIND_PULL;
        hit.slot = tpgw_pkg::SLOT_PORT3;
      end
      tpgw_pkg::ADDR_PORT0_DRIVE:
      begin
        hit.kind = tpgw_pkg::KIND_DRIVE;
        hit.slot = tpgw_pkg::SLOT_PORT0;
      end
      tpgw_pkg::ADDR_PORT1_DRIVE:
      begin
        hit.kind = tpgw_pkg::KIND_DRIVE;
        hit.slot = tpgw_pkg::SLOT_PORT1;
      end
      tpgw_pkg::ADDR_PORT3_DRIVE:
      begin
        hit.kind = tpgw_pkg::KIND_DRIVE;
        hit.slot = tpgw_pkg::SLOT_PORT3;
      end
      tpgw_pkg::ADDR_PORT0_WAKE:
      begin
        hit.kind = tpgw_pkg::KIND_WAKE;
        hit.slot = tpgw_pkg::SLOT_PORT0;
      end
      tpgw_pkg::ADDR_PORT1_WAKE:
      begin
        hit.kind = tpgw_pkg::KIND_WAKE;
        hit.slot = tpgw_pkg::SLOT_PORT1;
      end
      tpgw_pkg::ADDR_PORT3_WAKE:
      begin
        hit.kind = tpgw_pkg::KIND_WAKE;
        hit.slot = tpgw_pkg::SLOT_PORT3;
      end
      tpgw_pkg::ADDR_PORT0_FUNC:
      begin
        hit.kind = tpgw_pkg::KIND_FUNC;
        hit.slot = tpgw_pkg::SLOT_PORT0;
      end
      tpgw_pkg::ADDR_PORT1_FUNC:
      begin
        hit.kind = tpgw_pkg::KIND_FUNC;
        hit.slot = tpgw_pkg::SLOT_PORT1;
      end
      tpgw_pkg::ADDR_PORT3_FUNC:
      begin
        hit.kind = tpgw_pkg::KIND_FUNC;
        hit.slot = tpgw_pkg::SLOT_PORT3;
      end
      default:
      begin
        hit.valid = 1'b0;
      end
    endcase
    return hit;
  endfunction : decodeAddr

  // ****************************************
  // Next-state logic
  // ****************************************
  tpgw_pkg::tpgw_hit_type hit;
  logic [tpgw_pkg::NUM_PINS-1:0] drvOut;
  logic [tpgw_pkg::NUM_PINS-1:0] drvOe;
  logic [tpgw_pkg::NUM_PINS-1:0] padInputValue;
  logic [tpgw_pkg::NUM_PINS-1:0] wakeTerm;

  // ****************************************
  // Pin muxing
  // ****************************************
  // Per-pin muxing between GPIO and peripheral, pad value and wake term
  always_comb
  begin
    for (int p = 0; p < tpgw_pkg::NUM_PORTS; p++)
    begin
      for (int b = 0; b < tpgw_pkg::PORT_W; b++)
      begin
        // Peripheral-owned pins take value and enable from the peripheral
        if (state_q.funcSel[p][b])
        begin
          drvOut[p*8+b] = periphOut[p*8+b];
          drvOe[p*8+b] = periphOe[p*8+b];
        end
        else
        begin
          drvOut[p*8+b] = state_q.data[p][b];
          drvOe[p*8+b] = state_q.driveEnable[p][b];
        end
        // Driven pins read back their own drive value
        padInputValue[p*8+b] = drvOe[p*8+b] ? drvOut[p*8+b]
                                            : state_q.padSync2[p*8+b];
        // Only GPIO pins take part in wake; others hold the AND open
        wakeTerm[p*8+b] = state_q.funcSel[p][b] | state_q.wakeControlReg[p][b]
                          | padInputValue[p*8+b];
      end
    end
  end

  // ****************************************
  // Register file and pad control
  // ****************************************
  // Register file access, pin synchronisers and pad control registers
  always_comb
  begin
    state_d = state_q;
    hit = decodeAddr(sfrReq.addr);
    // Two-stage synchroniser on the pad inputs
    // Pads are asynchronous; logic reads only the second stage
    state_d.padSync1 = padIn;
    state_d.padSync2 = state_q.padSync1;
    // Reads
    // Reads see the registers as they stood before this edge
    state_d.rdata = tpgw_pkg::RDATA_UNMAPPED;
    if (sfrReq.rd && hit.valid)
    begin
      unique case (hit.kind)
        tpgw_pkg::KIND_DATA:
        begin
          if (sfrReq.rmw)
          begin
            state_d.rdata = state_q.data[hit.slot];
          end
          else
          begin
            state_d.rdata = padInputValue[hit.slot*8 +: 8];
          end
        end
        tpgw_pkg::KIND_PULL:
        begin
          state_d.rdata = state_q.pullUpEnable[hit.slot];
        end
        tpgw_pkg::KIND_DRIVE:
        begin
          state_d.rdata = state_q.driveEnable[hit.slot];
        end
        tpgw_pkg::KIND_WAKE:
        begin
          state_d.rdata = state_q.wakeControlReg[hit.slot];
        end
        tpgw_pkg::KIND_FUNC:
        begin
          state_d.rdata = state_q.funcSel[hit.slot];
        end
      endcase
    end
    // Byte writes
    // A byte write wins over a bit write in the same cycle
    if (sfrReq.wr && hit.valid)
    begin
      unique case (hit.kind)
        tpgw_pkg::KIND_DATA:
        begin
          state_d.data[hit.slot] = sfrReq.wdata;
        end
        tpgw_pkg::KIND_PULL:
        begin
          state_d.pullUpEnable[hit.slot] = sfrReq.wdata;
        end
        tpgw_pkg::KIND_DRIVE:
        begin
          state_d.driveEnable[hit.slot] = sfrReq.wdata;
        end
        tpgw_pkg::KIND_WAKE:
        begin
          state_d.wakeControlReg[hit.slot] = sfrReq.wdata;
        end
        tpgw_pkg::KIND_FUNC:
        begin
          state_d.funcSel[hit.slot] = sfrReq.wdata;
        end
      endcase
    end
    // Single-bit writes reach the data latches only
    else if (sfrReq.bitWr && hit.valid && hit.kind == tpgw_pkg::KIND_DATA)
    begin
      state_d.data[hit.slot][sfrReq.bitSel] = sfrReq.bitVal;
    end
    // Pad controls; drive enable high, output enable active low
    // Pull-up is dropped on driven pins, where it would only waste current
    state_d.pad.out = drvOut;
    state_d.pad.oenN = ~drvOe;
    for (int p = 0; p < tpgw_pkg::NUM_PORTS; p++)
    begin
      for (int b = 0; b < tpgw_pkg::PORT_W; b++)
      begin
        state_d.pad.pullUpEnable[p*8+b] = ~drvOe[p*8+b]
                                          & state_q.pullUpEnable[p][b];
      end
    end
    // Peripherals see the same pad value that a port read returns
    state_d.periphIn = padInputValue;
    // Wake line and its flag copy, neither writable by software
    // Line high means no pin asks for wake
    state_d.wakeLine = &wakeTerm;
    state_d.wakeFlag = state_q.wakeLine;
  end

  // ****************************************
  // State register
  // ****************************************
  // Synchronous reset; every pin leaves reset as an undriven input
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      state_q <= '0;
      // Control registers clear, so every pin floats without pull-up
      for (int p = 0; p < tpgw_pkg::NUM_PORTS; p++)
      begin
        state_q.data[p] <= tpgw_pkg::REG_RST;
        state_q.pullUpEnable[p] <= tpgw_pkg::REG_RST;
        state_q.driveEnable[p] <= tpgw_pkg::REG_RST;
        state_q.wakeControlReg[p] <= tpgw_pkg::REG_RST;
        state_q.funcSel[p] <= tpgw_pkg::REG_RST;
      end
      state_q.pad.oenN <= '1;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Every output is a flop; nothing stands after the state register
  assign sfrRdata = state_q.rdata;
  assign padCtrl = state_q.pad;
  assign periphIn = state_q.periphIn;
  assign pinWakeIrqLine = state_q.wakeLine;
  assign pinWakeIrqFlag = state_q.wakeFlag;

endmodule : tpgw_top

// [verif/tb_top.sv]
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Bench, model and sequence
  // ****************************************
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  tpgw_pkg::tpgw_sfr_req_type sfrReq = '0;
  logic [7:0] sfrRdata;
  logic [23:0] padIn, periphIn;
  logic [23:0] periphOut = 24'h000000;
  logic [23:0] periphOe = 24'h000000;
  logic [23:0] extDrive = 24'h000000;
  logic [23:0] extLevel = 24'h000000;
  tpgw_pkg::tpgw_pad_type padCtrl;
  logic pinWakeIrqLine, pinWakeIrqFlag;
  int num_errors = 0;
  int check_count = 0;
  // Slot order data, pull, drive, wake, func
  logic [7:0] regs [15] = '{8'h80, 8'hB2, 8'hB3, 8'hB4, 8'hC1, 8'h90, 8'hB5, 8'hB6, 8'hB7, 8'hC2,
    8'hB0, 8'hAA, 8'hAB, 8'hAC, 8'hC3};
  logic [7:0] mdl [15];
  logic [7:0] q;

  // Clock
  always #20 core_clk = ~core_clk;

  tpgw_top DUT (.core_clk(core_clk), .rstn(rstn), .sfrReq(sfrReq), .sfrRdata(sfrRdata), .padIn(padIn),
    .padCtrl(padCtrl), .periphOut(periphOut), .periphOe(periphOe), .periphIn(periphIn),
    .pinWakeIrqLine(pinWakeIrqLine), .pinWakeIrqFlag(pinWakeIrqFlag));
  tpgw_board u_board (.core_clk(core_clk), .padCtrl(padCtrl), .extDrive(extDrive), .extLevel(extLevel),
    .padIn(padIn));

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Op is rd, rmw, wr, bitWr; bit value comes from d[0]
  task automatic bus(input logic [3:0] op, input logic [7:0] a, input logic [7:0] d, input logic [2:0] b,
    output logic [7:0] rq);
    tpgw_pkg::tpgw_sfr_req_type r;
    r = '0;
    {r.rd, r.rmw, r.wr, r.bitWr} = op;
    r.addr = a;
    r.wdata = d;
    r.bitSel = b;
    r.bitVal = d[0];
    @(posedge core_clk);
    sfrReq <= r;
    @(posedge core_clk);
    sfrReq <= '0;
    @(negedge core_clk);
    rq = sfrRdata;
  endtask : bus

  task automatic do_reset();
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    foreach (mdl[i]) mdl[i] = 8'h00;
  endtask : do_reset

  // Data registers read through the latch path, the rest plainly
  task automatic chk_reset();
    for (int i = 0; i < 15; i++)
    begin
      bus((i % 5 == 0) ? 4'b1100 : 4'b1000, regs[i], 8'h00, 3'h0, q);
      chk(q, 8'h00);
    end
    chk(padCtrl.oenN, 24'hFFFFFF);
    chk(padCtrl.pullUpEnable, 24'h000000);
  endtask : chk_reset

  function automatic logic [23:0] vec(input int k);
    return {mdl[10 + k], mdl[5 + k], mdl[k]};
  endfunction : vec

  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    end_sim();
  end

  // Random register setups, pad levels and reads against the model
  initial
  begin
    logic [23:0] oe, dv, pin, ed, el, pe, po, wk;
    int s;
    int b;
    void'($urandom(69839));
    do_reset();
    chk_reset();
    bus(4'b0010, 8'h41, 8'h5A, 3'h0, q);
    bus(4'b1000, 8'h41, 8'h00, 3'h0, q);
    chk(q, 8'h00);
    // Read, byte write and bit write together: old latch read, byte wins
    bus(4'b1111, 8'h80, 8'hA5, 3'h1, q);
    chk(q, 8'h00);
    bus(4'b1100, 8'h80, 8'h00, 3'h0, q);
    chk(q, 8'hA5);
    for (int n = 0; n < 24; n++)
    begin
      foreach (mdl[i]) mdl[i] = (n == 0) ? ((i % 5 == 1) ? 8'hFF : 8'h00) : 8'($urandom);
      for (int i = 0; i < 15; i++)
      begin
        if (i % 5 == 4 && n % 2 == 0)
          mdl[i] = 8'h00;
        if (i % 5 == 1 && n % 2 == 1)
          mdl[i] = mdl[i] & ~mdl[i + 1];
        bus(4'b0010, regs[i], mdl[i], 3'h0, q);
      end
      s = $urandom_range(2);
      b = $urandom_range(7);
      bus(4'b0001, regs[s * 5], {7'h00, 1'(n % 2)}, b[2:0], q);
      mdl[s * 5][b] = 1'(n % 2);
      bus(4'b0001, regs[s * 5 + 2], 8'h01, b[2:0], q);
      pe = 24'($urandom);
      po = 24'($urandom);
      el = 24'($urandom);
      oe = (vec(4) & pe) | (~vec(4) & vec(2));
      dv = (vec(4) & po) | (~vec(4) & vec(0));
      ed = (n == 0) ? 24'h000000 : (24'($urandom) | ~vec(1)) & ~oe;
      pin = (oe & dv) | (~oe & ed & el) | (~oe & ~ed);
      wk = {23'h000000, &(vec(3) | vec(4) | pin)};
      @(posedge core_clk);
      periphOe <= pe;
      periphOut <= po;
      extDrive <= ed;
      extLevel <= el;
      repeat (6) @(posedge core_clk);
      @(negedge core_clk);
      chk(padCtrl.oenN, ~oe);
      chk(padCtrl.out & oe, dv & oe);
      chk(padCtrl.pullUpEnable, vec(1) & ~oe);
      chk(periphIn, pin);
      chk({23'h000000, pinWakeIrqLine}, wk);
      chk({23'h000000, pinWakeIrqFlag}, wk);
      for (int k = 0; k < 3; k++)
      begin
        bus(4'b1000, regs[k * 5], 8'h00, 3'h0, q);
        chk(q, pin[k * 8 +: 8]);
        bus(4'b1100, regs[k * 5], 8'h00, 3'h0, q);
        chk(q, mdl[k * 5]);
      end
    end
    do_reset();
    chk_reset();
    end_sim();
  end
endmodule : tb_top

bind tpgw_top tpgw_assertions #(.PORT_WIDTH(PORT_WIDTH)) u_chk (.core_clk(core_clk), .rstn(rstn),
  .sfrReq(sfrReq), .sfrRdata(sfrRdata), .padIn(padIn), .padCtrl(padCtrl), .periphOut(periphOut),
  .periphOe(periphOe), .periphIn(periphIn), .pinWakeIrqLine(pinWakeIrqLine), .pinWakeIrqFlag(pinWakeIrqFlag));

// [verif/tpgw_assertions.sv]
module tpgw_assertions #(
  parameter int PORT_WIDTH = 8
) (
  input wire logic core_clk,                              // System clock
  input wire logic rstn,                                  // Synchronous reset
  input wire tpgw_pkg::tpgw_sfr_req_type sfrReq,          // Register request
  input wire logic [7:0] sfrRdata,                        // Read data
  input wire logic [tpgw_pkg::NUM_PINS-1:0] padIn,        // Pin levels
  input wire tpgw_pkg::tpgw_pad_type padCtrl,             // Pad controls
  input wire logic [tpgw_pkg::NUM_PINS-1:0] periphOut,    // Peripheral values
  input wire logic [tpgw_pkg::NUM_PINS-1:0] periphOe,     // Peripheral enables
  input wire logic [tpgw_pkg::NUM_PINS-1:0] periphIn,     // Pad values to peripherals
  input wire logic pinWakeIrqLine,                        // Wake line
  input wire logic pinWakeIrqFlag                         // Wake flag
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Port behaviour checks
  // ****************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  property p_rdIdle;
    !sfrReq.rd |=> sfrRdata == 8'h00;
  endproperty
  a_rdIdle: assert property (p_rdIdle) else $error("read data not idle");

  property p_unmapped;
    sfrReq.rd && !sfrReq.addr[7] |=> sfrRdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  property p_resetState;
    $rose(rstn) |-> padCtrl.oenN == 24'hFFFFFF && padCtrl.pullUpEnable == 24'h000000 && !pinWakeIrqFlag;
  endproperty
  a_resetState: assert property (p_resetState) else $error("pins not idle after reset");

  property p_driveNoPull;
    (~padCtrl.oenN & padCtrl.pullUpEnable) == 24'h000000;
  endproperty
  a_driveNoPull: assert property (p_driveNoPull) else $error("pull-up on driven pin");

  property p_flagCopy;
    1'b1 |=> pinWakeIrqFlag == $past(pinWakeIrqLine);
  endproperty
  a_flagCopy: assert property (p_flagCopy) else $error("flag not a copy of line");

  property p_flagFell;
    $fell(pinWakeIrqLine) |=> $fell(pinWakeIrqFlag);
  endproperty
  a_flagFell: assert property (p_flagFell) else $error("flag did not follow line");

  property p_lineUp;
    padIn == 24'hFFFFFF [*3] |=> pinWakeIrqLine || padIn != 24'hFFFFFF;
  endproperty
  a_lineUp: assert property (p_lineUp) else $error("wake line low with all pins high");

  property p_periphInPad;
    (padCtrl.oenN == 24'hFFFFFF && $stable(padIn)) [*4] |=>
      padCtrl.oenN != 24'hFFFFFF || periphIn == $past(padIn);
  endproperty
  a_periphInPad: assert property (p_periphInPad) else $error("input value differs from pad");
endmodule : tpgw_assertions

// [verif/tpgw_board.sv]
module tpgw_board (
  input wire logic core_clk,                  // System clock
  input wire tpgw_pkg::tpgw_pad_type padCtrl, // Pad controls
  input wire logic [23:0] extDrive,           // Board driver on
  input wire logic [23:0] extLevel,           // Board driver level
  output logic [23:0] padIn                   // Pin levels
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Pin level resolution
  // ****************************************
  logic [23:0] floatQ = 24'h000000;

  // Floating pins change every cycle so no stale level is read
  always @(posedge core_clk)
  begin
    floatQ <= ~floatQ;
  end

  // Device drive wins, then board driver, then weak pull-up
  always_comb
  begin
    for (int i = 0; i < 24; i++)
    begin
      if (!padCtrl.oenN[i])
        padIn[i] = padCtrl.out[i];
      else if (extDrive[i])
        padIn[i] = extLevel[i];
      else if (padCtrl.pullUpEnable[i])
        padIn[i] = 1'b1;
      else
        padIn[i] = floatQ[i];
    end
  end
endmodule : tpgw_board
